// File: rtl/ics_switch_ctrl.sv
// input clock switch control for four pll channels with its register file
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// RULE1: per-channel hitless enable bit 2, resets one
// RULE2: hitless on: pll absorbs phase offset
// RULE3: hitless off: phase passes at loop bandwidth
// RULE4: sources give no gapped clocks when hitless
// RULE5: host never disables two inputs together
// RULE6: host sets register-controlled selection first
// RULE7: host reads sticky flags, exits if clear
// RULE8: host sets manual mode on lost active
// RULE9: host selects live input, reads back active
// RULE10: host restores non-revertive or revertive mode
// RULE11: host zeroes sticky flags at routine end
// RULE12: ramped switch enters holdover until ramp ready
// RULE13: ramped switch reuses holdover exit ramp rate
// RULE14: pull-in allowed within twenty ppm offset
// RULE15: six loop bandwidth registers per channel
// RULE16: no runt pulses, switch commits once
// RULE17: input enables reset on, clear powers down
// RULE18: revertive selects highest priority valid input
// RULE19: non-revertive keeps valid current input
// RULE20: no valid input means holdover
// RULE21: hitless change applies at next switch
module ics_switch_ctrl #(
  parameter int RAMP_CYCLES = ics_pkg::RAMP_CALC_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  input wire logic [3:0] los_live_in,
  input wire logic [3:0] input_valid_in,
  input wire logic [1:0] sel_pins_in,
  input wire logic selection_source_bit_in,
  input wire ics_pkg::ics_chan_ctrl_t [3:0] chan_ctrl_in,
  output ics_pkg::ics_chan_stat_t [3:0] chan_stat_out,
  output logic [3:0] input_buffer_power_out,
  output logic [3:0][47:0] loop_bw_out
);
  // ==========================================================
  // register file
  logic [7:0] los_flags;
  logic [7:0] next_los_flags;
  logic [7:0] input_en;
  logic [7:0] next_input_en;
  logic [3:0][7:0] hitless_ctrl;
  logic [3:0][7:0] next_hitless_ctrl;
  logic [3:0][5:0][7:0] lbw;
  logic [3:0][5:0][7:0] next_lbw;
  logic [7:0] next_rdata;
  logic next_rvalid;

  function automatic logic [15:0] hitless_addr(input int ch);
    case (ch)
      0: hitless_addr = ics_pkg::ADDR_HITLESS_A;
      1: hitless_addr = ics_pkg::ADDR_HITLESS_B;
      2: hitless_addr = ics_pkg::ADDR_HITLESS_C;
      default: hitless_addr = ics_pkg::ADDR_HITLESS_D;
    endcase
  endfunction

  function automatic logic [15:0] lbw_addr(input int ch, input int idx);
    logic [15:0] base;
    case (ch)
      0: base = ics_pkg::ADDR_LBW_A;
      1: base = ics_pkg::ADDR_LBW_B;
      2: base = ics_pkg::ADDR_LBW_C;
      default: base = ics_pkg::ADDR_LBW_D;
    endcase
    lbw_addr = base + 16'(idx);
  endfunction

  always_comb begin
    next_los_flags = los_flags;
    next_input_en = input_en;
    next_hitless_ctrl = hitless_ctrl;
    next_lbw = lbw;
    next_rdata = 8'h00;
    next_rvalid = reg_rd_in;
    if (reg_wr_in) begin
      if (reg_addr_in == ics_pkg::ADDR_LOS_FLAGS) begin
        // writing zero clears a flag, writing one leaves it
        next_los_flags = los_flags & reg_wdata_in;
      end
      if (reg_addr_in == ics_pkg::ADDR_INPUT_EN) begin
        next_input_en = reg_wdata_in; // see RULE17
      end
      for (int c = 0; c < ics_pkg::NUM_PLL; c++) begin
        if (reg_addr_in == hitless_addr(c)) begin
          next_hitless_ctrl[c] = reg_wdata_in; // see RULE1
        end
        for (int i = 0; i < ics_pkg::LBW_REGS; i++) begin
          if (reg_addr_in == lbw_addr(c, i)) begin
            next_lbw[c][i] = reg_wdata_in; // see RULE15
          end
        end
      end
    end
    // a new loss event wins over a clear in the same cycle
    next_los_flags[ics_pkg::LOS_W-1:0] = next_los_flags[ics_pkg::LOS_W-1:0] | los_live_in;
    next_los_flags[7:ics_pkg::LOS_W] = 4'h0;
    if (reg_rd_in) begin
      if (reg_addr_in == ics_pkg::ADDR_LOS_FLAGS) begin
        next_rdata = los_flags;
      end
      if (reg_addr_in == ics_pkg::ADDR_INPUT_EN) begin
        next_rdata = input_en;
      end
      for (int c = 0; c < ics_pkg::NUM_PLL; c++) begin
        if (reg_addr_in == hitless_addr(c)) begin
          next_rdata = hitless_ctrl[c];
        end
        for (int i = 0; i < ics_pkg::LBW_REGS; i++) begin
          if (reg_addr_in == lbw_addr(c, i)) begin
            next_rdata = lbw[c][i];
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      los_flags <= 8'h00;
      input_en <= ics_pkg::INPUT_EN_RESET;
      hitless_ctrl <= {ics_pkg::NUM_PLL{ics_pkg::HITLESS_CTRL_RESET}};
      lbw <= '0;
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      los_flags <= next_los_flags;
      input_en <= next_input_en;
      hitless_ctrl <= next_hitless_ctrl;
      lbw <= next_lbw;
      reg_rdata_out <= next_rdata;
      reg_rvalid_out <= next_rvalid;
    end
  end

  assign input_buffer_power_out = input_en[3:0]; // see RULE17
  assign loop_bw_out = lbw; // see RULE3

  // ==========================================================
  // selection pin synchroniser
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] pin_s3;
  logic [1:0] pin_sel;
  logic [1:0] next_pin_sel;

  always_comb begin
    next_pin_sel = (pin_s2 == pin_s3) ? pin_s3 : pin_sel;
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      pin_s1 <= 2'h0;
      pin_s2 <= 2'h0;
      pin_s3 <= 2'h0;
      pin_sel <= 2'h0;
    end else begin
      pin_s1 <= sel_pins_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_sel <= next_pin_sel;
    end
  end

  // ==========================================================
  // per-channel switch state machines
  ics_pkg::ics_sw_state_t [3:0] state;
  ics_pkg::ics_sw_state_t [3:0] next_state;
  logic [3:0][27:0] ramp_cnt;
  logic [3:0][27:0] next_ramp_cnt;
  ics_pkg::ics_chan_stat_t [3:0] stat;
  ics_pkg::ics_chan_stat_t [3:0] next_stat;
  logic [3:0] usable;
  logic [3:0][1:0] tgt;
  logic [3:0] tgt_ok;
  logic [2:0] best;
  // idle channel: no input yet, in holdover, buildout on, no pulses
  localparam ics_pkg::ics_chan_stat_t STAT_RESET = '{
    active_input: 2'h0, holdover: 1'b1, buildout: 1'b1, default: 1'b0};

  // lower input number has higher priority; msb flags a find
  function automatic logic [2:0] pick_best(input logic [3:0] ok);
    pick_best = 3'h0;
    for (int i = ics_pkg::NUM_IN - 1; i >= 0; i--) begin
      if (ok[i]) begin
        pick_best = {1'b1, 2'(i)};
      end
    end
  endfunction

  function automatic logic in_range(input logic signed [7:0] ppm);
    in_range = (ppm <= 8'(ics_pkg::PULLIN_LIMIT_PPM)) &&
               (ppm >= -8'(ics_pkg::PULLIN_LIMIT_PPM));
  endfunction

  assign usable = input_valid_in & input_en[3:0];
  assign best = pick_best(usable);

  always_comb begin
    next_state = state;
    next_ramp_cnt = ramp_cnt;
    next_stat = stat;
    tgt = '0;
    tgt_ok = '0;
    for (int c = 0; c < ics_pkg::NUM_PLL; c++) begin
      next_stat[c].switch_event = 1'b0;
      next_stat[c].ramp_exit = 1'b0;
      next_stat[c].pullin_ok = in_range(chan_ctrl_in[c].freq_offset_ppm); // see RULE14
      unique case (chan_ctrl_in[c].policy)
        ics_pkg::POLICY_MANUAL: begin
          tgt[c] = selection_source_bit_in ? chan_ctrl_in[c].choice : pin_sel;
          tgt_ok[c] = usable[tgt[c]];
        end
        ics_pkg::POLICY_NONREV: begin
          // an input that failed into holdover is not kept; pick afresh
          if (state[c] != ics_pkg::ST_HOLD && usable[stat[c].active_input]) begin
            tgt[c] = stat[c].active_input; // see RULE19
            tgt_ok[c] = 1'b1;
          end else begin
            tgt[c] = best[1:0];
            tgt_ok[c] = best[2];
          end
        end
        default: begin
          // revertive; the unused code behaves the same way
          tgt[c] = best[1:0]; // see RULE18
          tgt_ok[c] = best[2];
        end
      endcase
      unique case (state[c])
        ics_pkg::ST_TRACK: begin
          if (!tgt_ok[c]) begin
            next_state[c] = ics_pkg::ST_HOLD; // see RULE20
          end else if (tgt[c] != stat[c].active_input) begin
            // one commit per switch keeps the output free of runts, see RULE16
            next_stat[c].active_input = tgt[c];
            next_stat[c].switch_event = 1'b1;
            next_stat[c].buildout = hitless_ctrl[c][ics_pkg::HITLESS_BIT]; // see RULE21
            next_ramp_cnt[c] = 28'h0;
            if (chan_ctrl_in[c].ramp_en) begin
              next_state[c] = ics_pkg::ST_RAMP; // see RULE12
            end
          end
        end
        ics_pkg::ST_HOLD: begin
          if (tgt_ok[c]) begin
            next_stat[c].active_input = tgt[c];
            next_stat[c].switch_event = 1'b1;
            next_stat[c].buildout = hitless_ctrl[c][ics_pkg::HITLESS_BIT]; // see RULE2
            next_ramp_cnt[c] = 28'h0;
            next_state[c] = chan_ctrl_in[c].ramp_en ? ics_pkg::ST_RAMP : ics_pkg::ST_TRACK;
          end
        end
        ics_pkg::ST_RAMP: begin
          if (chan_ctrl_in[c].ramp_done || ramp_cnt[c] == 28'(RAMP_CYCLES - 1)) begin
            next_state[c] = ics_pkg::ST_TRACK;
            next_stat[c].ramp_exit = 1'b1; // see RULE13
          end else begin
            next_ramp_cnt[c] = ramp_cnt[c] + 28'h1;
          end
        end
        default: begin
          next_state[c] = ics_pkg::ST_HOLD;
        end
      endcase
      next_stat[c].holdover = (next_state[c] != ics_pkg::ST_TRACK);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      for (int c = 0; c < ics_pkg::NUM_PLL; c++) begin
        state[c] <= ics_pkg::ST_HOLD;
      end
      ramp_cnt <= '0;
      stat <= {ics_pkg::NUM_PLL{STAT_RESET}};
    end else begin
      state <= next_state;
      ramp_cnt <= next_ramp_cnt;
      stat <= next_stat;
    end
  end

  assign chan_stat_out = stat;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (srst_in);

  sequence s_switch_ramped;
    stat[0].switch_event && chan_ctrl_in[0].ramp_en;
  endsequence
  sequence s_ramp_hold;
    stat[0].holdover [*1] ##0 (state[0] == ics_pkg::ST_RAMP);
  endsequence

  hitless_write_a: assert property ((reg_wr_in && reg_addr_in == ics_pkg::ADDR_HITLESS_A) |=> hitless_ctrl[0][2] == $past(reg_wdata_in[2])) else $error("hitless bit not stored"); // see RULE1
  buildout_latch_a: assert property (stat[0].switch_event |-> stat[0].buildout == $past(hitless_ctrl[0][2])) else $error("buildout not taken at switch"); // see RULE2
  buildout_hold_a: assert property (!stat[0].switch_event |-> $stable(stat[0].buildout)) else $error("buildout changed without switch"); // see RULE21
  ramp_holdover_a: assert property (s_switch_ramped |-> s_ramp_hold) else $error("ramped switch not in holdover"); // see RULE12
  ramp_exit_a: assert property (stat[0].ramp_exit |-> !stat[0].holdover && $past(state[0]) == ics_pkg::ST_RAMP) else $error("ramp exit out of place"); // see RULE13
  revert_pick_a: assert property ((chan_ctrl_in[0].policy == ics_pkg::POLICY_REV && state[0] == ics_pkg::ST_TRACK && best[2] && best[1:0] != stat[0].active_input) |=> stat[0].active_input == $past(best[1:0]) && stat[0].switch_event) else $error("revertive pick wrong"); // see RULE18
  nonrev_keep_a: assert property ((chan_ctrl_in[0].policy == ics_pkg::POLICY_NONREV && state[0] == ics_pkg::ST_TRACK && usable[stat[0].active_input]) |=> $stable(stat[0].active_input)) else $error("non-revertive left valid input"); // see RULE19
  no_valid_a: assert property ((usable == 4'h0 && chan_ctrl_in[0].policy != ics_pkg::POLICY_MANUAL && state[0] != ics_pkg::ST_RAMP) |=> stat[0].holdover) else $error("no holdover without input"); // see RULE20
  buffer_power_a: assert property ((reg_wr_in && reg_addr_in == ics_pkg::ADDR_INPUT_EN) |=> input_buffer_power_out == $past(reg_wdata_in[3:0])) else $error("input enable not applied"); // see RULE17
  lbw_read_a: assert property ((reg_rd_in && reg_addr_in == ics_pkg::ADDR_LBW_D && !reg_wr_in) |=> reg_rvalid_out && reg_rdata_out == lbw[3][0]) else $error("loop bandwidth readback wrong"); // see RULE15
  pullin_a: assert property ((chan_ctrl_in[0].freq_offset_ppm > 8'sh14) |=> !stat[0].pullin_ok) else $error("pull-in range exceeded"); // see RULE14
  one_commit_a: assert property (stat[0].switch_event |=> !stat[0].switch_event) else $error("double switch commit"); // see RULE16
endmodule

`default_nettype wire

// File: rtl/ics_pkg.sv
// constants and carrier types for the input clock switch control block
package ics_pkg;
  localparam int NUM_IN = 4;
  localparam int NUM_PLL = 4;
  localparam int LBW_REGS = 6;
  localparam int LOS_W = 4;
  localparam logic [15:0] ADDR_LOS_FLAGS = 16'h0012;
  localparam logic [15:0] ADDR_INPUT_EN = 16'h0949;
  localparam logic [15:0] ADDR_HITLESS_A = 16'h0436;
  localparam logic [15:0] ADDR_HITLESS_B = 16'h0536;
  localparam logic [15:0] ADDR_HITLESS_C = 16'h0636;
  localparam logic [15:0] ADDR_HITLESS_D = 16'h0737;
  localparam logic [15:0] ADDR_LBW_A = 16'h0408;
  localparam logic [15:0] ADDR_LBW_B = 16'h0508;
  localparam logic [15:0] ADDR_LBW_C = 16'h0608;
  localparam logic [15:0] ADDR_LBW_D = 16'h0709;
  localparam int HITLESS_BIT = 2;
  localparam logic [7:0] HITLESS_CTRL_RESET = 8'h04;
  localparam logic [7:0] INPUT_EN_RESET = 8'h0f;
  localparam logic [7:0] LBW_RESET = 8'h00;
  localparam logic [1:0] POLICY_MANUAL = 2'h0;
  localparam logic [1:0] POLICY_NONREV = 2'h1;
  localparam logic [1:0] POLICY_REV = 2'h2;
  localparam int CLK_PERIOD_NS = 4;
  localparam int RAMP_CALC_NS = 1000000000;
  localparam int RAMP_CALC_CYCLES = RAMP_CALC_NS / CLK_PERIOD_NS;
  localparam int PULLIN_LIMIT_PPM = 20;

  typedef enum logic [2:0] {
    ST_TRACK = 3'h1,
    ST_HOLD = 3'h2,
    ST_RAMP = 3'h4
  } ics_sw_state_t;

  typedef struct packed {
    logic [1:0] policy;
    logic [1:0] choice;
    logic ramp_en;
    logic ramp_done;
    logic signed [7:0] freq_offset_ppm;
  } ics_chan_ctrl_t;

  typedef struct packed {
    logic [1:0] active_input;
    logic holdover;
    logic buildout;
    logic switch_event;
    logic ramp_exit;
    logic pullin_ok;
  } ics_chan_stat_t;
endpackage

// File: sim/ics_host_model.sv
// host model: register port cycles and the loss-of-signal service routine
`timescale 1ns/10ps
`default_nettype none
module ics_host_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic rvalid_in,
  input wire ics_pkg::ics_chan_stat_t [3:0] stat_in,
  output logic [15:0] addr_out,
  output logic [7:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  output logic [3:0][1:0] policy_out,
  output logic [3:0][1:0] choice_out,
  output logic src_out
);
  initial begin
    {addr_out, wdata_out, wr_out, rd_out, choice_out} = '0;
    policy_out = {4{ics_pkg::POLICY_REV}};
    src_out = 1'b1;
  end
  // ==========
  // register cycles
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    {addr_out, wdata_out, wr_out} <= {a, d, 1'b1};
    @(posedge clk_in);
    // released lines carry no stale value
    {addr_out, wdata_out, wr_out} <= {~a, ~d, 1'b0};
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_in);
    {addr_out, rd_out} <= {a, 1'b1};
    @(posedge clk_in);
    {addr_out, rd_out} <= {~a, 1'b0};
    #1;
    d = rvalid_in ? rdata_in : 8'hxx;
  endtask
  task automatic set_pol(input logic [1:0] p);
    @(posedge clk_in);
    policy_out <= {4{p}};
  endtask
  // ==========
  // service routine
  task automatic isr(input logic [1:0] auto_pol);
    logic [7:0] flags;
    int pick;
    rd(ics_pkg::ADDR_LOS_FLAGS, flags);
    if (flags[3:0] == 4'h0) return;
    pick = 0;
    while (pick < 3 && flags[pick]) pick++;
    @(posedge clk_in);
    for (int c = 0; c < 4; c++) begin
      if (flags[stat_in[c].active_input]) begin
        policy_out[c] <= ics_pkg::POLICY_MANUAL;
        choice_out[c] <= pick[1:0];
      end
    end
    for (int k = 0; k < 8 && stat_in[0].active_input != pick[1:0]; k++) begin
      @(posedge clk_in);
    end
    set_pol(auto_pol);
    wr(ics_pkg::ADDR_LOS_FLAGS, 8'h00);
  endtask
endmodule
`default_nettype wire

// File: sim/tb.sv
// self-checking bench for the input clock switch control block
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int RAMP = 20;
  localparam logic [15:0] HL [4] = '{ics_pkg::ADDR_HITLESS_A, ics_pkg::ADDR_HITLESS_B,
    ics_pkg::ADDR_HITLESS_C, ics_pkg::ADDR_HITLESS_D};
  localparam logic [15:0] LB [4] = '{ics_pkg::ADDR_LBW_A, ics_pkg::ADDR_LBW_B,
    ics_pkg::ADDR_LBW_C, ics_pkg::ADDR_LBW_D};
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] addr;
  logic [7:0] wdata, rdata;
  logic wr, rd, rvalid, src;
  logic [3:0] power;
  logic [3:0] los = 4'h0;
  logic [3:0] valid = 4'hf; // steady ungapped sources
  logic [3:0] ramp_en = 4'h0;
  logic [3:0] ramp_done = 4'h0;
  logic [3:0][7:0] offs = '0;
  logic [3:0][1:0] pol, choice;
  logic [3:0][47:0] lbw;
  ics_pkg::ics_chan_ctrl_t [3:0] ctrl;
  ics_pkg::ics_chan_stat_t [3:0] stat;
  int n_fail = 0;
  int num_checks = 0;
  int n;

  always #2 clk = ~clk;
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      ctrl[c] = {pol[c], choice[c], ramp_en[c], ramp_done[c], offs[c]};
    end
  end
  ics_switch_ctrl #(.RAMP_CYCLES(RAMP)) i_dut (
    .ref_clk_in(clk), .srst_in(srst), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .los_live_in(los), .input_valid_in(valid), .sel_pins_in(2'h0),
    .selection_source_bit_in(src), .chan_ctrl_in(ctrl), .chan_stat_out(stat),
    .input_buffer_power_out(power), .loop_bw_out(lbw));
  ics_host_model i_host (
    .clk_in(clk), .rdata_in(rdata), .rvalid_in(rvalid), .stat_in(stat), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .policy_out(pol), .choice_out(choice),
    .src_out(src));
  // ==========
  // helpers
  task automatic check(string what, logic [47:0] seen, logic [47:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rchk(logic [15:0] a, logic [7:0] exp);
    logic [7:0] d;
    i_host.rd(a, d);
    check("register", d, exp);
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  function automatic ics_pkg::ics_chan_stat_t st(logic [1:0] a, logic h, logic b, logic e);
    st = {a, h, b, e, 1'b0, 1'b1};
  endfunction
  task automatic wait_exit();
    n = 0;
    do begin
      tick(1);
      n++;
    end while (n < 60 && stat[0].ramp_exit !== 1'b1);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    stop_test();
  end
  // ==========
  // tests
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      rchk(HL[c], 8'h04);
    end
    rchk(ics_pkg::ADDR_INPUT_EN, 8'h0f);
    rchk(ics_pkg::ADDR_LOS_FLAGS, 8'h00);
    rchk(16'h0001, 8'h00);
    check("state", stat, {4{st(2'h0, 1'b0, 1'b1, 1'b0)}});
    $display("reset test done");
    i_host.wr(ics_pkg::ADDR_INPUT_EN, 8'h0e); // one input at a time
    i_host.wr(ics_pkg::ADDR_INPUT_EN, 8'h0a);
    tick(2);
    check("power", power, 4'ha);
    check("state", stat, {4{st(2'h1, 1'b0, 1'b1, 1'b0)}});
    i_host.wr(ics_pkg::ADDR_INPUT_EN, 8'h0f);
    tick(2);
    check("active", stat[0].active_input, 2'h0);
    for (int c = 0; c < 4; c++) begin
      i_host.wr(LB[c], 8'h50 | 8'(c));
      i_host.wr(LB[c] + 16'h0005, 8'ha0 | 8'(c));
    end
    tick(1);
    for (int c = 0; c < 4; c++) begin
      check("bandwidth", lbw[c], {8'ha0 | 8'(c), 32'h0, 8'h50 | 8'(c)});
    end
    rchk(LB[3], 8'h53);
    $display("register test done");
    @(posedge clk);
    valid <= 4'he;
    tick(1);
    check("state", stat, {4{st(2'h1, 1'b0, 1'b1, 1'b1)}});
    tick(1);
    check("state", stat, {4{st(2'h1, 1'b0, 1'b1, 1'b0)}});
    @(posedge clk);
    valid <= 4'hf;
    tick(1);
    check("active", stat[3].active_input, 2'h0);
    i_host.set_pol(ics_pkg::POLICY_NONREV);
    @(posedge clk);
    valid <= 4'he;
    tick(2);
    @(posedge clk);
    valid <= 4'hf;
    tick(3);
    check("state", stat, {4{st(2'h1, 1'b0, 1'b1, 1'b0)}});
    @(posedge clk);
    valid <= 4'h0;
    tick(2);
    check("state", stat, {4{st(2'h1, 1'b1, 1'b1, 1'b0)}});
    $display("switching test done");
    for (int c = 0; c < 4; c++) begin
      i_host.wr(HL[c], 8'h00);
    end
    rchk(HL[3], 8'h00);
    check("state", stat, {4{st(2'h1, 1'b1, 1'b1, 1'b0)}});
    @(posedge clk);
    valid <= 4'hf;
    tick(1);
    check("state", stat, {4{st(2'h0, 1'b0, 1'b0, 1'b1)}});
    for (int c = 0; c < 4; c++) begin
      i_host.wr(HL[c], 8'h04);
    end
    $display("hitless test done");
    i_host.set_pol(ics_pkg::POLICY_REV);
    @(posedge clk);
    ramp_en <= 4'h1;
    valid <= 4'he;
    tick(1);
    check("ramp entry", stat[0], st(2'h1, 1'b1, 1'b1, 1'b1));
    @(posedge clk);
    valid <= 4'hf;
    wait_exit();
    check("ramp time", 1'(n >= RAMP - 3 && n <= RAMP + 1), 1'b1);
    check("held input", stat[0].active_input, 2'h1);
    @(posedge clk);
    ramp_done <= 4'h1;
    wait_exit();
    check("ramp done", 1'(n <= 2), 1'b1);
    check("holdover", stat[0].holdover, 1'b0);
    @(posedge clk);
    {ramp_done, ramp_en} <= 8'h00;
    offs <= {8'heb, 8'hec, 8'h15, 8'h14};
    tick(3);
    for (int c = 0; c < 4; c++) begin
      check("pull-in", stat[c].pullin_ok, !c[0]);
    end
    @(posedge clk);
    offs <= '0;
    $display("ramp test done");
    i_host.set_pol(ics_pkg::POLICY_NONREV);
    @(posedge clk);
    los <= 4'h1;
    @(posedge clk);
    los <= 4'h0;
    rchk(ics_pkg::ADDR_LOS_FLAGS, 8'h01);
    i_host.isr(ics_pkg::POLICY_NONREV);
    tick(3);
    check("state", stat, {4{st(2'h1, 1'b0, 1'b1, 1'b0)}});
    rchk(ics_pkg::ADDR_LOS_FLAGS, 8'h00);
    $display("service test done");
    stop_test();
  end
endmodule
`default_nettype wire
